// ===== logic/adc_sequence_trigger_config.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// [RQ1] Any write to either configuration register aborts the running sequence; the code aborts only on writes with byte lane 0 strobed.
// [RQ2] Multi-channel wrap field picks last channel; codes six and up mean channel 5.
// [RQ3] Software avoids wrap code zero; single-channel mode converts channel 0 alone.
// [RQ4] In special modes software writes zero to wrap register bit 7.
// [RQ5] Trigger register bit 7 picks analog channel or dedicated trigger input.
// [RQ6] Unimplemented dedicated input: bit stored, trigger stays on analog channel.
// [RQ7] Analog class: codes 0-5 pick channels 0-5, codes 6-15 pick channel 5.
// [RQ8] Dedicated class: codes 0-3 pick inputs 0-3, higher codes reserved.
// [RQ9] Resolution field: 00 eight bits, 01 ten bits, 11 reserved.
// [RQ10] Discharge bit adds two cycles of capacitor discharge before sampling.
// [RQ11] Both registers are readable and writable at any time.
// [RQ12] Single-channel mode ignores the wrap field entirely.
module adc_sequence_trigger_config
  import adc_cfg_pkg::*;
#(
  parameter logic [3:0] ETRIG_PRESENT = 4'hF
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] trig_analog_channel,
  output logic [1:0] trig_dedicated_input,
  output logic trig_from_dedicated,
  output logic trig_reserved,
  output logic [3:0] result_width,
  output logic resolution_reserved,
  output logic seq_busy,
  output logic [2:0] seq_channel,
  output logic [2:0] seq_phase
);
  typedef struct packed {
    logic [7:0] wrap_channel_control;
    logic [7:0] trigger_resolution_control;
    logic multi_channel_select;
    logic start_pend;
    logic abort_pend;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [2:0] trig_an;
    logic [1:0] trig_ded;
    logic trig_ded_sel;
    logic trig_rsvd;
    logic [3:0] res_width;
    logic res_rsvd;
    logic busy;
    logic [2:0] chan;
    logic [2:0] phase;
  } top_type;
  top_type cur_ff;
  top_type nxt_cur;

  cfg_if cfg();

  adc_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg)
  );

  // Clamp a 4-bit channel code to the last analog channel
  function automatic logic [2:0] clamp_an(input logic [3:0] code);
    clamp_an = (code > {1'b0, LAST_AN}) ? LAST_AN : code[2:0];
  endfunction

  function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
    idx_ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= OPT_CTRL_IDX[ADDR_W-3:0]);
  endfunction

  logic aw_take;
  logic w_take;
  logic do_write;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [3:0] tch;
  logic tsrc;
  logic [1:0] sres;

  always_comb begin
    aw_take = s_axi_awvalid && cur_ff.awready;
    w_take = s_axi_wvalid && cur_ff.wready;
    do_write = 1'b0;
    wr_idx = cur_ff.aw_addr[ADDR_W-1:2];
    rd_idx = s_axi_araddr[ADDR_W-1:2];
    tch = cur_ff.trigger_resolution_control[TCH_MSB:0];
    tsrc = cur_ff.trigger_resolution_control[SRC_BIT];
    sres = cur_ff.trigger_resolution_control[RES_LSB+1:RES_LSB];
    nxt_cur = cur_ff;
    nxt_cur.abort_pend = 1'b0;
    nxt_cur.start_pend = 1'b0;
    if (aw_take) begin
      nxt_cur.aw_held = 1'b1;
      nxt_cur.aw_addr = s_axi_awaddr;
      nxt_cur.awready = 1'b0;
    end
    if (w_take) begin
      nxt_cur.w_held = 1'b1;
      nxt_cur.w_data = s_axi_wdata[7:0];
      nxt_cur.w_lane0 = s_axi_wstrb[0];
      nxt_cur.wready = 1'b0;
    end
    // Registers accept writes whatever the sequencer is doing
    if (cur_ff.aw_held && cur_ff.w_held && !cur_ff.bvalid) begin // [RQ11]
      do_write = 1'b1;
      nxt_cur.aw_held = 1'b0;
      nxt_cur.w_held = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = idx_ok(cur_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (idx_ok(cur_ff.aw_addr) && cur_ff.w_lane0) begin
        if (wr_idx == WRAP_CTRL_IDX[5:0]) begin
          nxt_cur.wrap_channel_control = cur_ff.w_data; // [RQ11]
          nxt_cur.abort_pend = 1'b1; // [RQ1]
        end
        if (wr_idx == TRIG_CTRL_IDX[5:0]) begin
          nxt_cur.trigger_resolution_control = cur_ff.w_data; // [RQ6]
          nxt_cur.abort_pend = 1'b1; // [RQ1]
        end
        if (wr_idx == SEQ_CTRL_IDX[5:0]) begin
          nxt_cur.start_pend = cur_ff.w_data[0];
          nxt_cur.abort_pend = cur_ff.w_data[1];
        end
        if (wr_idx == OPT_CTRL_IDX[5:0]) begin
          nxt_cur.multi_channel_select = cur_ff.w_data[0];
          // Mode change stops a sequence mid-way
          nxt_cur.abort_pend = 1'b1; // [RQ12]
        end
      end
    end
    if (cur_ff.bvalid && s_axi_bready) begin
      nxt_cur.bvalid = 1'b0;
      nxt_cur.awready = 1'b1;
      nxt_cur.wready = 1'b1;
    end
    if (cur_ff.rvalid && s_axi_rready) begin
      nxt_cur.rvalid = 1'b0;
      nxt_cur.arready = 1'b1;
    end
    if (s_axi_arvalid && cur_ff.arready) begin
      nxt_cur.arready = 1'b0;
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp = idx_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      nxt_cur.rdata = '0;
      if (idx_ok(s_axi_araddr)) begin
        unique case (rd_idx)
          WRAP_CTRL_IDX[5:0]: nxt_cur.rdata[7:0] = cur_ff.wrap_channel_control; // [RQ11]
          TRIG_CTRL_IDX[5:0]: nxt_cur.rdata[7:0] = cur_ff.trigger_resolution_control;
          SEQ_STAT_IDX[5:0]: nxt_cur.rdata[7:0] = {1'b0, cur_ff.phase, 1'b0, cur_ff.chan};
          SEQ_CTRL_IDX[5:0]: nxt_cur.rdata[7:0] = {7'h00, cur_ff.busy};
          OPT_CTRL_IDX[5:0]: nxt_cur.rdata[7:0] = {7'h00, cur_ff.multi_channel_select};
          default: nxt_cur.rdata = '0;
        endcase
      end
    end
    // Trigger source decode, a dedicated input only where fitted
    nxt_cur.trig_an = clamp_an(tch); // [RQ7]
    nxt_cur.trig_ded = tch[1:0];
    nxt_cur.trig_ded_sel = tsrc && (tch <= LAST_ETRIG) && ETRIG_PRESENT[tch[1:0]]; // [RQ5] [RQ6]
    nxt_cur.trig_rsvd = tsrc && (tch > LAST_ETRIG); // [RQ8]
    nxt_cur.res_width = (sres == RES_10) ? WIDTH_10 : WIDTH_8; // [RQ9]
    nxt_cur.res_rsvd = (sres == RES_RSVD); // [RQ9]
    nxt_cur.busy = cfg.busy;
    nxt_cur.chan = cfg.channel;
    nxt_cur.phase = cfg.phase;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '0;
      cur_ff.wrap_channel_control <= WRAP_CTRL_RST;
      cur_ff.trigger_resolution_control <= TRIG_CTRL_RST;
      cur_ff.awready <= 1'b1;
      cur_ff.wready <= 1'b1;
      cur_ff.arready <= 1'b1;
      cur_ff.trig_an <= LAST_AN;
      cur_ff.trig_ded <= 2'h3;
      cur_ff.res_width <= WIDTH_8;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cfg.wrap_channel = clamp_an(cur_ff.wrap_channel_control[WRAP_MSB:0]); // [RQ2]
  assign cfg.multi_channel_select = cur_ff.multi_channel_select; // [RQ12]
  assign cfg.discharge_before_sample = cur_ff.trigger_resolution_control[DIS_BIT]; // [RQ10]
  assign cfg.start = cur_ff.start_pend;
  assign cfg.abort = cur_ff.abort_pend; // [RQ1]

  assign s_axi_awready = cur_ff.awready;
  assign s_axi_wready = cur_ff.wready;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_arready = cur_ff.arready;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;
  assign trig_analog_channel = cur_ff.trig_an;
  assign trig_dedicated_input = cur_ff.trig_ded;
  assign trig_from_dedicated = cur_ff.trig_ded_sel;
  assign trig_reserved = cur_ff.trig_rsvd;
  assign result_width = cur_ff.res_width;
  assign resolution_reserved = cur_ff.res_rsvd;
  assign seq_busy = cur_ff.busy;
  assign seq_channel = cur_ff.chan;
  assign seq_phase = cur_ff.phase;

  chk_cfg_write_abort: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
    (do_write && cur_ff.w_lane0 && idx_ok(cur_ff.aw_addr)
      && (wr_idx == WRAP_CTRL_IDX[5:0] || wr_idx == TRIG_CTRL_IDX[5:0]))
    |=> cfg.abort ##1 !cfg.busy)
    else $error("config write did not abort sequence");
  chk_trig_analog: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
    !tsrc |=> trig_analog_channel == clamp_an($past(tch)) && !trig_from_dedicated)
    else $error("analog trigger channel decode wrong");
  chk_trig_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
    tsrc && tch >= 4'h4 |=> trig_reserved && !trig_from_dedicated)
    else $error("reserved dedicated code not flagged");
  chk_absent_input: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
    tsrc && tch <= LAST_ETRIG && !ETRIG_PRESENT[tch[1:0]] |=> !trig_from_dedicated)
    else $error("absent dedicated input selected");
  chk_res_width: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
    sres == RES_10 |=> result_width == WIDTH_10)
    else $error("resolution width wrong");
  chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    do_write |=> s_axi_bvalid)
    else $error("write not answered");

  // Bus handshakes: refusal while busy, answers held until taken
  chk_awready_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    aw_take |=> !s_axi_awready)
    else $error("write address taken while busy");
  chk_wready_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    w_take |=> !s_axi_wready)
    else $error("write data taken while busy");
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_bvalid_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  chk_arready_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_rvalid_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  chk_bresp_okay: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    do_write && idx_ok(cur_ff.aw_addr) |=> s_axi_bresp == RESP_OKAY)
    else $error("good write refused");
  chk_bresp_err: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    do_write && !idx_ok(cur_ff.aw_addr) |=> s_axi_bresp == RESP_SLVERR)
    else $error("bad write address accepted");
  chk_rresp_err: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_arvalid && s_axi_arready && !idx_ok(s_axi_araddr)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("bad read address accepted");

  // Register storage and readback, mode-write abort, start pulse
  chk_wrap_store: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    (do_write && cur_ff.w_lane0 && idx_ok(cur_ff.aw_addr) && wr_idx == WRAP_CTRL_IDX[5:0])
    |=> cur_ff.wrap_channel_control == $past(cur_ff.w_data))
    else $error("wrap register write lost");
  chk_trig_store: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
    (do_write && cur_ff.w_lane0 && idx_ok(cur_ff.aw_addr) && wr_idx == TRIG_CTRL_IDX[5:0])
    |=> cur_ff.trigger_resolution_control == $past(cur_ff.w_data))
    else $error("trigger register write lost");
  chk_lane_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    do_write && !cur_ff.w_lane0
    |=> $stable(cur_ff.wrap_channel_control) && $stable(cur_ff.trigger_resolution_control))
    else $error("write without lane 0 stored");
  chk_read_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {WRAP_CTRL_IDX[5:0], 2'h0}
    |=> s_axi_rdata[7:0] == $past(cur_ff.wrap_channel_control))
    else $error("wrap register read wrong");
  chk_read_trig: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {TRIG_CTRL_IDX[5:0], 2'h0}
    |=> s_axi_rdata[7:0] == $past(cur_ff.trigger_resolution_control))
    else $error("trigger register read wrong");
  chk_opt_abort: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ12]
    (do_write && cur_ff.w_lane0 && idx_ok(cur_ff.aw_addr) && wr_idx == OPT_CTRL_IDX[5:0])
    |=> cfg.abort)
    else $error("mode change did not stop sequence");
  chk_start_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
    cfg.start |=> !cfg.start)
    else $error("start held longer than one cycle");

  // Trigger, resolution and wrap decode, sequencer status copy
  chk_trig_dedicated: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    tsrc && tch <= LAST_ETRIG && ETRIG_PRESENT[tch[1:0]]
    |=> trig_from_dedicated && {2'h0, trig_dedicated_input} == $past(tch))
    else $error("dedicated trigger input not selected");
  chk_analog_class: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    !tsrc |=> !trig_reserved)
    else $error("analog class flagged reserved");
  chk_res_eight: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
    sres != RES_10 |=> result_width == WIDTH_8)
    else $error("eight bit width wrong");
  chk_res_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
    sres == RES_RSVD |=> resolution_reserved)
    else $error("reserved resolution not flagged");
  chk_res_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
    sres != RES_RSVD |=> !resolution_reserved)
    else $error("valid resolution flagged reserved");
  chk_wrap_clamp: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
    cur_ff.wrap_channel_control[WRAP_MSB:0] >= {1'b0, LAST_AN} |-> cfg.wrap_channel == LAST_AN)
    else $error("wrap code not clamped");
  chk_wrap_pass: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
    cur_ff.wrap_channel_control[WRAP_MSB:0] < {1'b0, LAST_AN}
    |-> {1'b0, cfg.wrap_channel} == cur_ff.wrap_channel_control[WRAP_MSB:0])
    else $error("wrap code altered");
  chk_status_copy: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
    1'b1 |=> seq_busy == $past(cfg.busy) && seq_channel == $past(cfg.channel))
    else $error("sequencer status copy wrong");
endmodule

// ===== logic/adc_cfg_pkg.sv
package adc_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Printed offsets are indices; byte address is four times the index
  localparam logic [7:0] WRAP_CTRL_IDX = 8'h00;
  localparam logic [7:0] TRIG_CTRL_IDX = 8'h01;
  localparam logic [7:0] SEQ_CTRL_IDX = 8'h02;
  localparam logic [7:0] SEQ_STAT_IDX = 8'h03;
  localparam logic [7:0] OPT_CTRL_IDX = 8'h04;
  localparam logic [7:0] WRAP_CTRL_RST = 8'h0F;
  localparam logic [7:0] TRIG_CTRL_RST = 8'h0F;
  localparam logic [7:0] OPT_CTRL_RST = 8'h00;
  localparam logic [7:0] WRAP_MASK = 8'h0F;
  localparam int WRAP_MSB = 3;
  localparam int TCH_MSB = 3;
  localparam int DIS_BIT = 4;
  localparam int RES_LSB = 5;
  localparam int SRC_BIT = 7;
  localparam logic [2:0] LAST_AN = 3'h5;
  localparam logic [3:0] LAST_ETRIG = 4'h3;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_RSVD = 2'h3;
  localparam logic [3:0] WIDTH_8 = 4'h8;
  localparam logic [3:0] WIDTH_10 = 4'hA;
  localparam logic [1:0] DIS_EXTRA = 2'h2;
  localparam logic [1:0] SAMPLE_BASE = 2'h2;
  localparam logic [2:0] CONV_CYCLES = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DISCH, SEQ_SAMPLE, SEQ_CONV} seq_state_type;
endpackage

// ===== logic/cfg_if.sv
`timescale 1ns/1ps
interface cfg_if;
  logic [2:0] wrap_channel;
  logic multi_channel_select;
  logic discharge_before_sample;
  logic start;
  logic abort;
  logic busy;
  logic [2:0] channel;
  logic [2:0] phase;
  modport ctrl(output wrap_channel, multi_channel_select, discharge_before_sample, start,
    abort, input busy, channel, phase);
  modport seq(input wrap_channel, multi_channel_select, discharge_before_sample, start,
    abort, output busy, channel, phase);
endinterface

// ===== logic/adc_sequencer.sv
`timescale 1ns/1ps
module adc_sequencer
  import adc_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  cfg_if.seq cfg
);
  typedef struct packed {
    seq_state_type st;
    logic [2:0] chan;
    logic [2:0] cnt;
  } seq_type;
  seq_type cur_ff;
  seq_type nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (cfg.abort) begin
      nxt_cur.st = SEQ_IDLE; // [RQ1]
      nxt_cur.cnt = 3'h0;
    end else begin
      unique case (cur_ff.st)
        SEQ_IDLE: begin
          if (cfg.start) begin
            nxt_cur.chan = 3'h0;
            nxt_cur.cnt = 3'h0;
            nxt_cur.st = cfg.discharge_before_sample ? SEQ_DISCH : SEQ_SAMPLE; // [RQ10]
          end
        end
        SEQ_DISCH: begin
          nxt_cur.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.cnt[1:0] == DIS_EXTRA - 2'h1) begin // [RQ10]
            nxt_cur.st = SEQ_SAMPLE;
            nxt_cur.cnt = 3'h0;
          end
        end
        SEQ_SAMPLE: begin
          nxt_cur.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.cnt[1:0] == SAMPLE_BASE - 2'h1) begin
            nxt_cur.st = SEQ_CONV;
            nxt_cur.cnt = 3'h0;
          end
        end
        SEQ_CONV: begin
          nxt_cur.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.cnt == CONV_CYCLES - 3'h1) begin
            nxt_cur.cnt = 3'h0;
            // Single-channel mode ignores the wrap point
            if (!cfg.multi_channel_select || cur_ff.chan >= cfg.wrap_channel) begin // [RQ12] [RQ2]
              nxt_cur.chan = 3'h0;
              nxt_cur.st = SEQ_IDLE;
            end else begin
              nxt_cur.chan = cur_ff.chan + 3'h1;
              nxt_cur.st = cfg.discharge_before_sample ? SEQ_DISCH : SEQ_SAMPLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '{st: SEQ_IDLE, chan: 3'h0, cnt: 3'h0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cfg.busy = (cur_ff.st != SEQ_IDLE);
  assign cfg.channel = cur_ff.chan;
  assign cfg.phase = {1'b0, cur_ff.st};

  chk_abort_idles: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
    cfg.abort |=> cur_ff.st == SEQ_IDLE)
    else $error("sequence not aborted by register write");
  chk_discharge_len: assert property (@(posedge aclk) disable iff (!aresetn || cfg.abort) // [RQ10]
    (cur_ff.st != SEQ_DISCH && nxt_cur.st == SEQ_DISCH) |=>
    cur_ff.st == SEQ_DISCH ##1 cur_ff.st == SEQ_DISCH ##1 cur_ff.st != SEQ_DISCH || cfg.abort)
    else $error("discharge phase not two cycles");
  chk_no_discharge: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ10]
    !cfg.discharge_before_sample && cur_ff.st == SEQ_IDLE |=> cur_ff.st != SEQ_DISCH)
    else $error("discharge without option");
  chk_wrap_limit: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
    cur_ff.st != SEQ_IDLE |-> cur_ff.chan <= LAST_AN)
    else $error("channel beyond wrap limit");
  chk_single_chan: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ12]
    !cfg.multi_channel_select && !cfg.abort && cur_ff.st != SEQ_IDLE |-> cur_ff.chan == 3'h0)
    else $error("single mode left channel 0");
endmodule

// ===== testbench/adc_sequence_trigger_config_tb.sv
`timescale 1ns/1ps
module adc_sequence_trigger_config_tb
  import adc_cfg_pkg::*;
();
  localparam logic [3:0] FITTED = 4'h7;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [2:0] trig_analog_channel, seq_channel, seq_phase;
  logic [1:0] trig_dedicated_input;
  logic trig_from_dedicated, trig_reserved, resolution_reserved, seq_busy;
  logic [3:0] result_width;
  int errors = 0;
  int checks = 0;
  logic [7:0] trig_exp;

  always #12.5 aclk = ~aclk;

  adc_sequence_trigger_config #(.ETRIG_PRESENT(FITTED)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trig_analog_channel(trig_analog_channel),
    .trig_dedicated_input(trig_dedicated_input), .trig_from_dedicated(trig_from_dedicated),
    .trig_reserved(trig_reserved), .result_width(result_width),
    .resolution_reserved(resolution_reserved), .seq_busy(seq_busy),
    .seq_channel(seq_channel), .seq_phase(seq_phase)
  );

  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    d = '0;
    r = 2'h1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask

  task automatic wok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk(r, RESP_OKAY);
  endtask

  function automatic logic [2:0] exp_an(input logic [3:0] c);
    return (c > 4'h5) ? 3'h5 : c[2:0];
  endfunction

  task automatic chk_trig();
    logic [3:0] c;
    logic ded;
    c = trig_exp[3:0];
    ded = trig_exp[7] && c <= 4'h3 && FITTED[c[1:0]];
    chk(trig_from_dedicated, ded);
    chk(trig_reserved, trig_exp[7] && c >= 4'h4);
    if (ded) chk(trig_dedicated_input, c[1:0]);
    else if (!trig_exp[7] || c <= 4'h3) chk(trig_analog_channel, exp_an(c));
    chk(result_width, (trig_exp[6:5] == 2'h1) ? 4'hA : 4'h8);
    chk(resolution_reserved, trig_exp[6:5] == 2'h3);
  endtask

  // Configure, start, watch channels and discharge phases, then rewrite the wrap register once the sequence has ended
  task automatic seq_run(input logic multi, input logic [7:0] wrap, input logic dis,
                         output logic [2:0] mx, output int ent, output int cnt);
    logic [2:0] prev;
    wok(8'h10, {7'h0, multi});
    wok(8'h00, wrap);
    wok(8'h04, {3'h0, dis, 4'h0});
    wok(8'h08, 8'h01);
    mx = 3'h0;
    ent = 0;
    cnt = 0;
    prev = 3'h0;
    repeat (120) begin
      @(posedge aclk);
      if (seq_busy === 1'b1 && seq_channel > mx) mx = seq_channel;
      if (seq_phase === 3'h1) begin
        cnt++;
        if (prev !== 3'h1) ent++;
      end
      prev = seq_phase;
    end
    wok(8'h00, wrap);
  endtask

  logic [7:0] corner [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hFF,
                              8'h05, 8'h06, 8'h20, 8'h40, 8'h60, 8'h10};
  logic [7:0] wraps [5] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h0F};
  logic [7:0] stop_addr [3] = '{8'h00, 8'h04, 8'h08};
  logic [7:0] stop_data [3] = '{8'h05, 8'h00, 8'h02};

  initial begin
    logic [7:0] d;
    logic [31:0] rv;
    logic [1:0] r;
    logic [2:0] mx, m1;
    int ent, cnt, seed;
    seed = $urandom(32'h64C68E07);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, WRAP_CTRL_RST);
    rchk(8'h04, TRIG_CTRL_RST);
    trig_exp = TRIG_CTRL_RST;
    chk_trig();
    for (int i = 0; i < 48; i++) begin
      d = (i < 12) ? corner[i] : 8'($urandom);
      wok(8'h04, d);
      trig_exp = d;
      settle(3);
      chk_trig();
      rchk(8'h04, d);
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom_range(15, 1));
      wok(8'h00, d);
      rchk(8'h00, d);
    end
    wr(8'h04, 8'hA5, 4'h0, r);
    chk(r, RESP_OKAY);
    rchk(8'h04, trig_exp);
    wr(8'h05, 8'hA5, 4'hF, r);
    chk(r, RESP_SLVERR);
    rchk(8'h04, trig_exp);
    rd(8'h14, rv, r);
    chk(r, RESP_SLVERR);
    chk(rv, 32'h0);
    foreach (wraps[i]) begin
      seq_run(1'b1, wraps[i], 1'b0, mx, ent, cnt);
      chk(mx, exp_an(wraps[i][3:0]));
      chk(ent, 0);
    end
    seq_run(1'b0, 8'h01, 1'b0, m1, ent, cnt);
    chk(m1, 3'h0);
    seq_run(1'b0, 8'h0F, 1'b0, mx, ent, cnt);
    chk(mx, m1);
    seq_run(1'b1, 8'h02, 1'b1, mx, ent, cnt);
    chk(mx, 3'h2);
    chk(ent, 32'h3);
    chk(cnt, 2 * ent);
    for (int k = 0; k < 3; k++) begin
      wok(8'h10, 8'h01);
      wok(8'h00, 8'h05);
      wok(8'h04, 8'h00);
      wok(8'h08, 8'h01);
      settle(3);
      chk(seq_busy, 1'b1);
      rchk(8'h08, 8'h01);
      rchk(8'h10, 8'h01);
      wok(stop_addr[k], stop_data[k]);
      settle(3);
      chk(seq_busy, 1'b0);
    end
    summarize();
  end
endmodule
